// [rtl/txd_pkg.sv]
// Shared constants and types for the table-write, test-skip and XOR execution block.
package txd_pkg;
  localparam int unsigned PTR_W = 21;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned HOLD_COUNT = 8;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_BANK = 8'h0C;
  localparam logic [7:0] ADDR_TPTR = 8'h10;
  localparam logic [7:0] ADDR_TLAT = 8'h14;
  localparam logic [7:0] ADDR_CYCLES = 8'h18;
  localparam logic [7:0] ADDR_DADDR = 8'h1C;
  localparam logic [7:0] ADDR_DATA = 8'h20;
  localparam logic [2:0] HOLD_PAGE = 3'h2;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_SKIP_BIT = 1;
  localparam int unsigned STAT_Z_BIT = 2;
  localparam int unsigned STAT_N_BIT = 3;
  localparam logic [13:0] OPC_TABLE_WRITE = 14'h0003;
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0A;
  localparam logic [5:0] OPC_XOR_REG = 6'h06;
  localparam logic [3:0] OPC_TWO_WORD_A = 4'hC;
  localparam logic [3:0] OPC_TWO_WORD_B = 4'hE;
  localparam int unsigned BANK_BIT = 8;
  localparam int unsigned DEST_BIT = 9;
  localparam logic [1:0] PTR_KEEP = 2'h0;
  localparam logic [1:0] PTR_POST_INC = 2'h1;
  localparam logic [1:0] PTR_POST_DEC = 2'h2;
  localparam logic [1:0] PTR_PRE_INC = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_DADDR = 12'h000;
  localparam logic [20:0] RST_PTR = 21'h000000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} txd_phase_type;
  typedef enum logic [1:0] {ST_IDLE, ST_CYCLE1, ST_CYCLE2} txd_state_type;
  typedef enum logic [2:0] {OP_NOP, OP_TABLE_WRITE_OP, OP_TEST_REG_SKIP_ZERO_OP, OP_XOR_LITERAL_TO_ACC_OP, OP_XOR_ACC_WITH_REG_OP} txd_op_type;
endpackage

// [rtl/txd_regfile.sv]
// Byte-wide data register file with one combinational read port and one write port.
`timescale 1ns/1ps
`default_nettype none
module txd_regfile import txd_pkg::*; (
  input wire logic sys_clk,
  input wire logic [DADDR_W-1:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [1 << DADDR_W];

  assign rdata = mem[addr];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule // txd_regfile
`default_nettype wire

// [rtl/txd_core.sv]
// Execution engine for table write, test-and-skip and the two XOR forms, behind an AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module txd_core import txd_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  txd_state_type state_reg;
  txd_phase_type phase_reg, phase_next;
  txd_op_type op_reg, op_dec;
  logic [15:0] instr_reg;
  logic discard_reg, skip_reg, n_reg, z_reg;
  logic [7:0] acc_reg, operand_reg, result_reg, tlat_reg, latch_buf_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [PTR_W-1:0] tptr_reg;
  logic [DADDR_W-1:0] daddr_reg;
  logic [31:0] cycles_reg, status_word;
  logic [7:0] hold_reg [HOLD_COUNT];
  logic [7:0] rf_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire aw_hold_next = (aw_hold_reg && !wr_fire) || aw_take;
  wire w_hold_next = (w_hold_reg && !wr_fire) || w_take;
  wire ar_take = s_axi_arvalid && arready_reg;
  wire rvalid_next = (rvalid_reg && !s_axi_rready) || ar_take;
  wire busy = state_reg != ST_IDLE;
  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Data and mask come in as arguments so that every caller re-evaluates when the held write changes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [31:0] mask);
    lane_merge = (old_val & ~mask) | (new_val & mask);
  endfunction

  wire wh_instr = aw_addr_reg == ADDR_INSTR;
  wire wh_acc = aw_addr_reg == ADDR_ACC;
  wire wh_bank = aw_addr_reg == ADDR_BANK;
  wire wh_tptr = aw_addr_reg == ADDR_TPTR;
  wire wh_tlat = aw_addr_reg == ADDR_TLAT;
  wire wh_daddr = aw_addr_reg == ADDR_DADDR;
  wire wh_data = aw_addr_reg == ADDR_DATA;
  wire wr_mapped = wh_instr || wh_acc || wh_bank || wh_tptr || wh_tlat || wh_daddr || wh_data;
  wire wr_ok = wr_fire && wr_mapped && !busy;
  wire start = wr_ok && wh_instr;
  wire [31:0] wv_instr = lane_merge({16'h0000, instr_reg}, w_data_reg, wmask);
  wire [31:0] wv_acc = lane_merge({24'h000000, acc_reg}, w_data_reg, wmask);
  wire [31:0] wv_bank = lane_merge({28'h0000000, bank_reg}, w_data_reg, wmask);
  wire [31:0] wv_tptr = lane_merge({11'h000, tptr_reg}, w_data_reg, wmask);
  wire [31:0] wv_tlat = lane_merge({24'h000000, tlat_reg}, w_data_reg, wmask);
  wire [31:0] wv_daddr = lane_merge({20'h00000, daddr_reg}, w_data_reg, wmask);
  wire [31:0] wv_data = lane_merge({24'h000000, rf_rdata}, w_data_reg, wmask);
  wire new_two_word = (wv_instr[15:12] == OPC_TWO_WORD_A) || (wv_instr[15:12] == OPC_TWO_WORD_B);

  wire rh_instr = s_axi_araddr == ADDR_INSTR;
  wire rh_status = s_axi_araddr == ADDR_STATUS;
  wire rh_acc = s_axi_araddr == ADDR_ACC;
  wire rh_bank = s_axi_araddr == ADDR_BANK;
  wire rh_tptr = s_axi_araddr == ADDR_TPTR;
  wire rh_tlat = s_axi_araddr == ADDR_TLAT;
  wire rh_cycles = s_axi_araddr == ADDR_CYCLES;
  wire rh_daddr = s_axi_araddr == ADDR_DADDR;
  wire rh_data = s_axi_araddr == ADDR_DATA;
  wire rh_hold = (s_axi_araddr[7:5] == HOLD_PAGE) && (s_axi_araddr[1:0] == 2'h0);
  wire rd_mapped = rh_instr || rh_status || rh_acc || rh_bank || rh_tptr || rh_tlat || rh_cycles
                   || rh_daddr || rh_data || rh_hold;
  wire rd_err = !rd_mapped || (rh_data && busy);
  wire [31:0] rd_val = rd_err ? RST_WORD :
                       rh_instr ? {16'h0000, instr_reg} :
                       rh_status ? status_word :
                       rh_acc ? {24'h000000, acc_reg} :
                       rh_bank ? {28'h0000000, bank_reg} :
                       rh_tptr ? {11'h000, tptr_reg} :
                       rh_tlat ? {24'h000000, tlat_reg} :
                       rh_cycles ? cycles_reg :
                       rh_daddr ? {20'h00000, daddr_reg} :
                       rh_data ? {24'h000000, rf_rdata} :
                       {24'h000000, hold_reg[s_axi_araddr[4:2]]};

  always_comb begin
    status_word = RST_WORD;
    status_word[STAT_BUSY_BIT] = busy;
    status_word[STAT_SKIP_BIT] = skip_reg;
    status_word[STAT_Z_BIT] = z_reg;
    status_word[STAT_N_BIT] = n_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_addr_reg <= RST_BYTE;
      w_data_reg <= RST_WORD;
      w_strb_reg <= 4'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awready_reg <= !aw_hold_next;
      wready_reg <= !w_hold_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rdata_reg <= RST_WORD;
      rresp_reg <= RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_val;
        rresp_reg <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode; a discarded word executes as a no-operation.
  wire [1:0] ptr_mode = instr_reg[1:0];
  wire [7:0] lit = instr_reg[7:0];
  assign op_dec = discard_reg ? OP_NOP :
                  (instr_reg[15:2] == OPC_TABLE_WRITE) ? OP_TABLE_WRITE_OP :
                  (instr_reg[15:9] == OPC_TEST_SKIP) ? OP_TEST_REG_SKIP_ZERO_OP :
                  (instr_reg[15:8] == OPC_XOR_LIT) ? OP_XOR_LITERAL_TO_ACC_OP :
                  (instr_reg[15:10] == OPC_XOR_REG) ? OP_XOR_ACC_WITH_REG_OP : OP_NOP;

  wire c1 = state_reg == ST_CYCLE1;
  wire c2 = state_reg == ST_CYCLE2;
  wire q1 = busy && phase_reg == PH_Q1;
  wire q2 = busy && phase_reg == PH_Q2;
  wire q3 = busy && phase_reg == PH_Q3;
  wire q4 = busy && phase_reg == PH_Q4;
  wire xor_q4 = q4 && c1 && (op_reg == OP_XOR_LITERAL_TO_ACC_OP || op_reg == OP_XOR_ACC_WITH_REG_OP);
  wire acc_we = q4 && c1 && (op_reg == OP_XOR_LITERAL_TO_ACC_OP || (op_reg == OP_XOR_ACC_WITH_REG_OP && !instr_reg[DEST_BIT]));
  wire eng_rf_we = q4 && c1 && op_reg == OP_XOR_ACC_WITH_REG_OP && instr_reg[DEST_BIT];
  wire tst_q4 = q4 && c1 && op_reg == OP_TEST_REG_SKIP_ZERO_OP;
  wire pre_step = q3 && c1 && op_reg == OP_TABLE_WRITE_OP && ptr_mode == PTR_PRE_INC;
  wire hold_we = q4 && c2;
  wire [2:0] hold_sel = {tptr_reg[2:1], tptr_reg[0]};
  wire [DADDR_W-1:0] rf_addr = !busy ? daddr_reg :
                               instr_reg[BANK_BIT] ? {bank_reg, lit} : {ACCESS_BANK, lit};
  wire rf_we = busy ? eng_rf_we : (wr_ok && wh_data);
  wire [7:0] rf_wdata = busy ? result_reg : wv_data[7:0];

  txd_regfile u_regfile (
    .sys_clk(sys_clk),
    .addr(rf_addr),
    .we(rf_we),
    .wdata(rf_wdata),
    .rdata(rf_rdata)
  );

  always_comb begin
    case (phase_reg)
      PH_Q1: phase_next = PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      default: phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_Q1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= PH_Q1;
          if (start) begin
            state_reg <= ST_CYCLE1;
          end
        end
        ST_CYCLE1, ST_CYCLE2: begin
          phase_reg <= phase_next;
          if (phase_reg == PH_Q4) begin
            state_reg <= (c1 && op_reg == OP_TABLE_WRITE_OP) ? ST_CYCLE2 : ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      instr_reg <= RST_INSTR;
      discard_reg <= 1'b0;
      skip_reg <= 1'b0;
      op_reg <= OP_NOP;
    end else begin
      if (start) begin
        instr_reg <= wv_instr[15:0];
        discard_reg <= skip_reg;
        skip_reg <= skip_reg && new_two_word;
      end else if (tst_q4) begin
        skip_reg <= operand_reg == RST_BYTE;
      end
      if (q1 && c1) begin
        op_reg <= op_dec;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      operand_reg <= RST_BYTE;
      result_reg <= RST_BYTE;
      latch_buf_reg <= RST_BYTE;
      cycles_reg <= RST_WORD;
    end else begin
      if (q2 && c1) begin
        operand_reg <= (op_reg == OP_XOR_LITERAL_TO_ACC_OP) ? lit : rf_rdata;
      end
      if (q3 && c1) begin
        result_reg <= acc_reg ^ operand_reg;
      end
      if (q2 && c2) begin
        latch_buf_reg <= tlat_reg;
      end
      if (q4) begin
        cycles_reg <= cycles_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= RST_BYTE;
      n_reg <= 1'b0;
      z_reg <= 1'b0;
    end else begin
      if (wr_ok && wh_acc) begin
        acc_reg <= wv_acc[7:0];
      end else if (acc_we) begin
        acc_reg <= result_reg;
      end
      if (xor_q4) begin
        n_reg <= result_reg[7];
        z_reg <= result_reg == RST_BYTE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bank_reg <= RST_BANK;
      tlat_reg <= RST_BYTE;
      daddr_reg <= RST_DADDR;
      tptr_reg <= RST_PTR;
    end else begin
      if (wr_ok && wh_bank) bank_reg <= wv_bank[BANK_W-1:0];
      if (wr_ok && wh_tlat) tlat_reg <= wv_tlat[7:0];
      if (wr_ok && wh_daddr) daddr_reg <= wv_daddr[DADDR_W-1:0];
      if (wr_ok && wh_tptr) begin
        tptr_reg <= wv_tptr[PTR_W-1:0];
      end else if (pre_step || (hold_we && ptr_mode == PTR_POST_INC)) begin
        tptr_reg <= tptr_reg + 21'h1;
      end else if (hold_we && ptr_mode == PTR_POST_DEC) begin
        tptr_reg <= tptr_reg - 21'h1;
      end
    end
  end

  for (genvar i = 0; i < HOLD_COUNT; i++) begin : g_hold
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        hold_reg[i] <= RST_BYTE;
      end else if (hold_we && hold_sel == 3'(i)) begin
        hold_reg[i] <= latch_buf_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] seen_idx_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) seen_idx_reg <= 3'h0;
    else if (hold_we) seen_idx_reg <= tptr_reg[2:0];
  end
  wire [7:0] seen_hold = hold_reg[seen_idx_reg];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_table_write_op_length: assert property (q2 && c1 && op_reg == OP_TABLE_WRITE_OP |-> busy [*7] ##1 !busy)
    else $error("table write did not take two cycles");
  a_xor_length: assert property (q2 && c1 && (op_reg == OP_XOR_LITERAL_TO_ACC_OP || op_reg == OP_XOR_ACC_WITH_REG_OP) |-> busy [*3] ##1 !busy)
    else $error("xor did not take one cycle");
  a_hold_index: assert property (hold_we |=> seen_hold == $past(latch_buf_reg))
    else $error("holding register not written with latch byte");
  a_post_inc: assert property (hold_we && ptr_mode == PTR_POST_INC |=> tptr_reg == $past(tptr_reg) + 21'h1)
    else $error("post increment wrong");
  a_post_dec: assert property (hold_we && ptr_mode == PTR_POST_DEC |=> tptr_reg == $past(tptr_reg) - 21'h1)
    else $error("post decrement wrong");
  a_pre_inc: assert property (pre_step |=> tptr_reg == $past(tptr_reg) + 21'h1 ##1 $stable(tptr_reg) [*5])
    else $error("pre increment wrong");
  a_ptr_keep: assert property (busy && !q1 && op_reg == OP_TABLE_WRITE_OP && ptr_mode == PTR_KEEP |=> $stable(tptr_reg))
    else $error("pointer moved in keep mode");
  a_latch_read: assert property (q2 && c2 |=> latch_buf_reg == $past(tlat_reg))
    else $error("latch not read in second phase");
  a_flags_xor: assert property (xor_q4 |=> z_reg == ($past(result_reg) == 8'h00) && n_reg == $past(result_reg[7]))
    else $error("xor flags wrong");
  a_flags_hold: assert property (q4 && (op_reg == OP_TABLE_WRITE_OP || op_reg == OP_TEST_REG_SKIP_ZERO_OP) |=> $stable({n_reg, z_reg}))
    else $error("flags changed by non-xor");
  a_skip_arm: assert property (tst_q4 |=> skip_reg == ($past(operand_reg) == 8'h00))
    else $error("skip not armed on zero");
  a_skip_discard: assert property (start && skip_reg |=> discard_reg ##1 op_reg == OP_NOP)
    else $error("skipped word not discarded");
  a_acc_literal: assert property (q4 && c1 && op_reg == OP_XOR_LITERAL_TO_ACC_OP |=> acc_reg == ($past(acc_reg) ^ $past(lit)))
    else $error("literal xor result wrong");
  a_bank_fixed: assert property (busy && !instr_reg[BANK_BIT] |-> rf_addr[DADDR_W-1:8] == ACCESS_BANK)
    else $error("access bank not used");
endmodule // txd_core
`default_nettype wire

// [testbench/txd_host.sv]
// Register bus master model that stands in for the host software.
`timescale 1ns/1ps
`default_nettype none
module txd_host (
  input wire logic sys_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // Write: both channels offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b0;
  endtask

  // Read: address held until taken, rready held until the data is seen.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
endmodule // txd_host
`default_nettype wire

// [testbench/txd_core_tb_top.sv]
// Self-checking testbench for the table write, test-skip and XOR engine.
`timescale 1ns/1ps
`default_nettype none
module txd_core_tb_top import txd_pkg::*; ;
  logic sys_clk, nrst;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [33:0] wq [$];
  logic [33:0] rq [$];
  int errors = 0;
  int n_compared = 0;
  int ncyc = 0;
  int seed = 2662;
  logic [7:0] acc, k, d0, d1;
  logic zf = 1'b0;
  logic nf = 1'b0;
  logic sk = 1'b0;
  logic [20:0] p, np;
  logic [1:0] m;
  logic [20:0] tp [4] = '{21'h1FFFFF, 21'h000000, 21'h01389A, 21'h00A356};
  logic [7:0] rst_addr [8] = '{ADDR_INSTR, ADDR_STATUS, ADDR_ACC, ADDR_BANK, ADDR_TPTR, ADDR_TLAT,
    ADDR_CYCLES, ADDR_DADDR};

  txd_core u_txd_core (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  txd_host u_txd_host (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs, input logic [3:0] s);
    wq.push_back({32'h00000000, rs});
    u_txd_host.wr(a, d, s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    wrs(a, d, rs, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs);
    rq.push_back({rs, e});
    u_txd_host.rd(a);
  endtask

  task automatic exec(input logic [15:0] ins, input int cyc);
    wr(ADDR_INSTR, {16'h0000, ins}, RESP_OKAY);
    ncyc += cyc;
    repeat (12) @(posedge sys_clk);
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    wr(ADDR_DADDR, {20'h00000, a}, RESP_OKAY);
    wr(ADDR_DATA, {24'h000000, v}, RESP_OKAY);
  endtask

  function automatic logic [31:0] stat();
    return {28'h0000000, nf, zf, sk, 1'b0};
  endfunction

  // Each bus answer is matched against the oldest expectation.
  always @(posedge sys_clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", {32'h00000000, bresp}, wq.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) chk("rdata", {rresp, rdata}, rq.pop_front());
  end

  initial begin
    #2000000;
    errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rst_addr[i]) rd(rst_addr[i], 32'h00000000, RESP_OKAY);
    rd(8'h3C, 32'h00000000, RESP_SLVERR);
    wr(8'h3C, 32'h000000FF, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      acc = 8'($random(seed));
      k = (i == 0) ? acc : 8'($random(seed));
      wr(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
      exec({8'h0A, k}, 1);
      acc = acc ^ k;
      zf = (acc == 8'h00);
      nf = acc[7];
      rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
      rd(ADDR_STATUS, stat(), RESP_OKAY);
    end
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    wr(ADDR_BANK, 32'h00000003, RESP_OKAY);
    poke(12'h340, d0);
    poke(12'h040, d1);
    exec(16'h1B40, 1);
    d0 = d0 ^ acc;
    zf = (d0 == 8'h00);
    nf = d0[7];
    wr(ADDR_DADDR, 32'h00000340, RESP_OKAY);
    rd(ADDR_DATA, {24'h000000, d0}, RESP_OKAY);
    rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    exec(16'h1840, 1);
    acc = acc ^ d1;
    zf = (acc == 8'h00);
    nf = acc[7];
    rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    wr(ADDR_DADDR, 32'h00000040, RESP_OKAY);
    rd(ADDR_DATA, {24'h000000, d1}, RESP_OKAY);
    poke(12'h050, 8'h00);
    exec(16'h6650, 1);
    sk = 1'b1;
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    exec(16'h0A55, 1);
    sk = 1'b0;
    rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
    exec(16'h6650, 1);
    exec(16'hC123, 1);
    sk = 1'b1;
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    exec(16'h0A55, 1);
    sk = 1'b0;
    rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
    poke(12'h050, 8'h01);
    exec(16'h6650, 1);
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    rd(ADDR_CYCLES, 32'(ncyc), RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      k = 8'($random(seed));
      wr(ADDR_TPTR, {11'h000, tp[i]}, RESP_OKAY);
      wr(ADDR_TLAT, {24'h000000, k}, RESP_OKAY);
      exec({14'h0003, m}, 2);
      p = (m == PTR_PRE_INC) ? tp[i] + 21'h000001 : tp[i];
      np = (m == PTR_POST_INC) ? p + 21'h000001 : (m == PTR_POST_DEC) ? p - 21'h000001 : p;
      rd(8'h40 + {3'h0, p[2:0], 2'h0}, {24'h000000, k}, RESP_OKAY);
      rd(ADDR_TPTR, {11'h000, np}, RESP_OKAY);
    end
    rd(ADDR_STATUS, stat(), RESP_OKAY);
    wr(ADDR_INSTR, 32'h0000000C, RESP_OKAY);
    wr(ADDR_ACC, 32'h00000077, RESP_SLVERR);
    ncyc += 2;
    repeat (12) @(posedge sys_clk);
    wrs(ADDR_ACC, 32'hFFFFFF5A, RESP_OKAY, 4'hE);
    rd(ADDR_ACC, {24'h000000, acc}, RESP_OKAY);
    wrs(ADDR_ACC, 32'hFFFFFF5A, RESP_OKAY, 4'h1);
    rd(ADDR_ACC, 32'h0000005A, RESP_OKAY);
    rd(ADDR_CYCLES, 32'(ncyc), RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule // txd_core_tb_top
`default_nettype wire
